/* File: sbc_core.sv */
// Purpose: Memory-side command, mode register and burst data core.
// Assumes: Link clock ck_i is much slower than clock_i and is oversampled.
// Notes:   Latency and burst settings arrive as static inputs from this clock.
//
// Overview of operation
// - Bank mask register: bit set blocks bank
// - Upper four mask bits are dropped
// - Mask acts only during self-refresh
// - Read of 20H returns pattern A
// - Read of 28H returns pattern B
// - Write to 3FH resets the core
// - Activate opens bank and row
// - Access command, bit two picks read
// - Column from rising and falling halves
// - Strobe preamble low, data edge aligned
// - First datum read latency after command
// - Back-to-back reads run gapless
// - Interrupted read ends at interrupt point
// - Write beats captured on strobe edges
// - Burst stop truncates latest access
`timescale 1ns/10ps
`default_nettype none
module sbc_core #(
  parameter logic [7:0] CAL_PATTERN_A = 8'h55,
  parameter logic [7:0] CAL_PATTERN_B = 8'h33
) (
  input  wire logic                       clock_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       ck_i,
  input  wire logic                       cs_n_i,
  input  wire logic [sbc_pkg::CA_W-1:0]   cmd_addr_bus_i,
  input  wire logic [sbc_pkg::DQ_W-1:0]   dq_i,
  output logic      [sbc_pkg::DQ_W-1:0]   dq_o,
  output logic                            dq_oe_n_o,
  input  wire logic                       dqs_i,
  output logic                            dqs_t_o,
  output logic                            dqs_c_o,
  output logic                            dqs_oe_n_o,
  input  wire logic [3:0]                 read_latency_i,
  input  wire logic [3:0]                 write_latency_i,
  input  wire logic [1:0]                 burst_length_i,
  input  wire logic                       self_refresh_i,
  output logic      [sbc_pkg::BANK_N-1:0] bank_open_o,
  output logic      [sbc_pkg::BANK_N-1:0] sr_bank_mask_o,
  output logic      [sbc_pkg::BANK_N-1:0] refresh_bank_en_o,
  output logic                            access_error_o,
  output logic                            write_overrun_o,
  output logic                            wr_fifo_ready_o,
  output logic                            soft_reset_o
);

  typedef struct packed {
    logic                                       ck_d;
    logic                                       dqs_d;
    logic                                       rise_cmd;
    logic [sbc_pkg::CA_W-1:0]                   ca_rise;
    sbc_pkg::sbc_pipe_ent_s [sbc_pkg::PIPE_DEPTH-1:0] pipe;
    logic [sbc_pkg::BANK_N-1:0]                 bank_open;
    logic [sbc_pkg::BANK_N-1:0][sbc_pkg::ROW_W-1:0] open_row;
    logic [sbc_pkg::BANK_N-1:0]                 sr_mask;
    logic [sbc_pkg::BANK_N-1:0]                 refresh_en;
    logic                                       last_rd;
    sbc_pkg::sbc_rd_state_e                     rd_st;
    logic [sbc_pkg::BEAT_W-1:0]                 rd_beat;
    logic [sbc_pkg::BEAT_W-1:0]                 rd_len;
    logic [sbc_pkg::BANK_W-1:0]                 rd_bank;
    logic [sbc_pkg::MCOL_W-1:0]                 rd_col;
    logic                                       rd_mrr;
    logic [7:0]                                 rd_data;
    sbc_pkg::sbc_wr_state_e                     wr_st;
    logic [sbc_pkg::BEAT_W-1:0]                 wr_beat;
    logic [sbc_pkg::BEAT_W-1:0]                 wr_len;
    logic [sbc_pkg::BANK_W-1:0]                 wr_bank;
    logic [sbc_pkg::MCOL_W-1:0]                 wr_col;
    logic [sbc_pkg::DQ_W-1:0]                   dq_out;
    logic                                       dq_oe_n;
    logic                                       dqs_out;
    logic                                       dqs_oe_n;
    logic                                       access_err;
    logic                                       overrun;
    logic                                       soft_rst;
    logic [sbc_pkg::MEM_WORDS-1:0][sbc_pkg::DQ_W-1:0] mem;
  } sbc_core_state_s;

  function automatic sbc_core_state_s reset_state();
    sbc_core_state_s r;
    r            = '0;
    r.sr_mask    = sbc_pkg::SR_MASK_RESET;
    r.refresh_en = sbc_pkg::ALL_BANKS;
    r.dq_oe_n    = 1'b1;
    r.dqs_oe_n   = 1'b1;
    r.rd_st      = sbc_pkg::RD_IDLE;
    r.wr_st      = sbc_pkg::WR_IDLE;
    reset_state  = r;
  endfunction : reset_state

  sbc_core_state_s                st_reg;
  sbc_core_state_s                st_next;
  logic [sbc_pkg::SYNC_W-1:0]     pins_s;
  logic                           ck_s;
  logic                           cs_n_s;
  logic [sbc_pkg::CA_W-1:0]       ca_s;
  logic [sbc_pkg::DQ_W-1:0]       dq_s;
  logic                           dqs_s;
  logic                           ck_rise;
  logic                           ck_fall;
  logic [2:0]                     rl_m1;
  logic [2:0]                     rl_m2;
  logic [2:0]                     wl_m1;
  logic                           cap_valid;
  logic [sbc_pkg::FIFO_WIDTH-1:0] cap_data;
  logic                           cap_ready;
  logic                           drain_valid;
  logic                           drain_ready;
  logic [sbc_pkg::FIFO_WIDTH-1:0] drain_data;
  logic                           fifo_rst;

  // Every pin passes two flops before the edge finders see it
  sbc_sync #(
    .W (sbc_pkg::SYNC_W)
  ) u_pin_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .d_i       ({ck_i, cs_n_i, cmd_addr_bus_i, dq_i, dqs_i}),
    .q_o       (pins_s)
  );

  assign {ck_s, cs_n_s, ca_s, dq_s, dqs_s} = pins_s;
  assign ck_rise     = ck_s & ~st_reg.ck_d;
  assign ck_fall     = ~ck_s & st_reg.ck_d;
  assign rl_m1       = read_latency_i[2:0] - 3'h1;
  assign rl_m2       = read_latency_i[2:0] - 3'h2;
  assign wl_m1       = write_latency_i[2:0] - 3'h1;
  // Read bursts own the array; write beats wait in the FIFO meanwhile
  assign drain_ready = (st_reg.rd_st != sbc_pkg::RD_BURST);
  assign fifo_rst    = sys_rst_i | st_reg.soft_rst;

  sbc_fifo #(
    .WIDTH (sbc_pkg::FIFO_WIDTH),
    .DEPTH (sbc_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clock_i     (clock_i),
    .sys_rst_i   (fifo_rst),
    .ce_i        (ce_i),
    .in_valid_i  (cap_valid),
    .in_ready_o  (cap_ready),
    .in_data_i   (cap_data),
    .out_valid_o (drain_valid),
    .out_ready_i (drain_ready),
    .out_data_o  (drain_data)
  );

  always_comb begin
    sbc_pkg::sbc_pipe_ent_s     ent;
    sbc_pkg::sbc_pipe_ent_s     tap;
    logic [sbc_pkg::CA_W-1:0]   ca_r;
    logic [sbc_pkg::BANK_W-1:0] bank;
    logic [7:0]                 ma;
    logic [7:0]                 op;
    ent       = '0;
    tap       = '0;
    ca_r      = st_reg.ca_rise;
    bank      = ca_r[sbc_pkg::BANK_LSB +: sbc_pkg::BANK_W];
    ma        = {ca_s[1:0], ca_r[sbc_pkg::MA_R_LSB +: 6]};
    op        = ca_s[sbc_pkg::OP_F_LSB +: 8];
    cap_valid = 1'b0;
    cap_data  = '0;
    st_next   = st_reg;
    st_next.ck_d     = ck_s;
    st_next.dqs_d    = dqs_s;
    st_next.soft_rst = 1'b0;
    st_next.refresh_en = self_refresh_i ? ~st_reg.sr_mask : sbc_pkg::ALL_BANKS;

    if (drain_valid && drain_ready) begin
      st_next.mem[drain_data[sbc_pkg::DQ_W +: sbc_pkg::MIDX_W]] =
        drain_data[sbc_pkg::DQ_W-1:0];
    end

    // Write beats on either strobe edge while the window is open
    if (st_reg.wr_st == sbc_pkg::WR_OPEN && (dqs_s ^ st_reg.dqs_d)) begin
      cap_valid = 1'b1;
      cap_data  = {sbc_pkg::mem_idx(st_reg.wr_bank, st_reg.wr_col, st_reg.wr_beat), dq_s};
      if (!cap_ready) begin
        st_next.overrun = 1'b1;
      end
      st_next.wr_beat = st_reg.wr_beat + 5'h01;
      if (st_reg.wr_beat + 5'h01 >= st_reg.wr_len) begin
        st_next.wr_st = sbc_pkg::WR_IDLE;
      end
    end

    // Read data advances on every link clock edge
    if ((ck_rise || ck_fall) && st_reg.rd_st == sbc_pkg::RD_BURST) begin
      if (st_reg.rd_beat >= st_reg.rd_len) begin
        st_next.rd_st    = sbc_pkg::RD_IDLE;
        st_next.dq_oe_n  = 1'b1;
        st_next.dqs_oe_n = 1'b1;
        st_next.dqs_out  = 1'b0;
      end else begin
        st_next.dq_out  = st_reg.rd_mrr ? {8'h00, st_reg.rd_data} :
                          st_reg.mem[sbc_pkg::mem_idx(st_reg.rd_bank, st_reg.rd_col,
                                                      st_reg.rd_beat)];
        st_next.dqs_out = ~st_reg.dqs_out;
        st_next.rd_beat = st_reg.rd_beat + 5'h01;
      end
    end

    if (ck_rise) begin
      st_next.rise_cmd = ~cs_n_s;
      st_next.ca_rise  = ca_s;

      // Preamble one link period ahead of the first strobe rise
      tap = st_reg.pipe[rl_m2];
      if ((tap.kind == sbc_pkg::PK_READ || tap.kind == sbc_pkg::PK_MRR) &&
          st_next.rd_st != sbc_pkg::RD_BURST) begin
        st_next.rd_st    = sbc_pkg::RD_PRE;
        st_next.dqs_oe_n = 1'b0;
        st_next.dqs_out  = 1'b0;
      end

      tap = st_reg.pipe[rl_m1];
      if (tap.kind == sbc_pkg::PK_BST_RD && st_reg.rd_st == sbc_pkg::RD_BURST) begin
        st_next.rd_st    = sbc_pkg::RD_IDLE;
        st_next.dq_oe_n  = 1'b1;
        st_next.dqs_oe_n = 1'b1;
        st_next.dqs_out  = 1'b0;
      end
      // A newer read takes over here, so the older one ends early
      if (tap.kind == sbc_pkg::PK_READ || tap.kind == sbc_pkg::PK_MRR) begin
        st_next.rd_st    = sbc_pkg::RD_BURST;
        st_next.rd_bank  = tap.bank;
        st_next.rd_col   = tap.col;
        st_next.rd_mrr   = (tap.kind == sbc_pkg::PK_MRR);
        st_next.rd_data  = tap.data;
        st_next.rd_len   = (tap.kind == sbc_pkg::PK_MRR) ? sbc_pkg::BEATS_4 :
                           sbc_pkg::burst_beats(burst_length_i);
        st_next.rd_beat  = 5'h01;
        st_next.dq_out   = (tap.kind == sbc_pkg::PK_MRR) ? {8'h00, tap.data} :
                           st_reg.mem[sbc_pkg::mem_idx(tap.bank, tap.col, 5'h00)];
        st_next.dq_oe_n  = 1'b0;
        st_next.dqs_out  = 1'b1;
        st_next.dqs_oe_n = 1'b0;
      end

      tap = st_reg.pipe[wl_m1];
      if (tap.kind == sbc_pkg::PK_BST_WR) begin
        st_next.wr_st = sbc_pkg::WR_IDLE;
      end
      if (tap.kind == sbc_pkg::PK_WRITE) begin
        st_next.wr_st   = sbc_pkg::WR_OPEN;
        st_next.wr_bank = tap.bank;
        st_next.wr_col  = tap.col;
        st_next.wr_beat = 5'h00;
        st_next.wr_len  = sbc_pkg::burst_beats(burst_length_i);
      end

      st_next.pipe[0] = '0;
      for (int i = 1; i < sbc_pkg::PIPE_DEPTH; i++) begin
        st_next.pipe[i] = st_reg.pipe[i-1];
      end
    end else if (ck_fall && st_reg.rise_cmd) begin
      st_next.rise_cmd = 1'b0;
      if (ca_r[1:0] == sbc_pkg::CMD2_ACT) begin
        st_next.bank_open[bank] = 1'b1;
        st_next.open_row[bank]  = {ca_s, ca_r[sbc_pkg::ROW_R_LSB +: 5]};
      end else if (ca_r[1:0] == sbc_pkg::CMD2_ACCESS) begin
        ent.kind = ca_r[sbc_pkg::RD_SEL_BIT] ? sbc_pkg::PK_READ : sbc_pkg::PK_WRITE;
        ent.bank = bank;
        // Only the low column bits index the small array
        ent.col  = {ca_s[sbc_pkg::COL_F_LSB +: 2], ca_r[sbc_pkg::COL_R_LSB +: 2]};
        st_next.pipe[0] = ent;
        st_next.last_rd = ca_r[sbc_pkg::RD_SEL_BIT];
        if (!st_reg.bank_open[bank]) begin
          st_next.access_err = 1'b1;
        end
      end else begin
        case (ca_r[3:0])
          sbc_pkg::CMD4_BST: begin
            ent.kind = st_reg.last_rd ? sbc_pkg::PK_BST_RD : sbc_pkg::PK_BST_WR;
            st_next.pipe[0] = ent;
          end
          sbc_pkg::CMD4_PRE: begin
            if (ca_r[sbc_pkg::AB_BIT]) begin
              st_next.bank_open = '0;
            end else begin
              st_next.bank_open[bank] = 1'b0;
            end
          end
          sbc_pkg::CMD4_MRW: begin
            if (ma == sbc_pkg::MA_SR_BANK_MASK) begin
              st_next.sr_mask = op[3:0];
            end else if (ma == sbc_pkg::MA_SOFT_RESET) begin
              st_next          = reset_state();
              st_next.soft_rst = 1'b1;
            end
          end
          sbc_pkg::CMD4_MRR: begin
            ent.kind = sbc_pkg::PK_MRR;
            ent.data = (ma == sbc_pkg::MA_CAL_A) ? CAL_PATTERN_A :
                       (ma == sbc_pkg::MA_CAL_B) ? CAL_PATTERN_B : 8'h00;
            st_next.pipe[0] = ent;
          end
          default: begin
          end
        endcase
      end
    end

    if (sys_rst_i) begin
      st_next = reset_state();
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || ce_i) begin
      st_reg <= st_next;
    end
  end

  assign dq_o              = st_reg.dq_out;
  assign dq_oe_n_o         = st_reg.dq_oe_n;
  assign dqs_t_o           = st_reg.dqs_out;
  assign dqs_c_o           = ~st_reg.dqs_out;
  assign dqs_oe_n_o        = st_reg.dqs_oe_n;
  assign bank_open_o       = st_reg.bank_open;
  assign sr_bank_mask_o    = st_reg.sr_mask;
  assign refresh_bank_en_o = st_reg.refresh_en;
  assign access_error_o    = st_reg.access_err;
  assign write_overrun_o   = st_reg.overrun;
  assign wr_fifo_ready_o   = cap_ready;
  assign soft_reset_o      = st_reg.soft_rst;

endmodule : sbc_core
`default_nettype wire

/* File: sbc_pkg.sv */
// Purpose: Shared constants, types and helpers of the SDRAM bank command core.
// Assumes: x16 data, four banks, command/address bus of ten bits.
// Notes:   Command codes compare against the rising-edge half of the bus.
`default_nettype none
package sbc_pkg;

  localparam int CA_W        = 10;
  localparam int DQ_W        = 16;
  localparam int BANK_N      = 4;
  localparam int BANK_W      = 2;
  localparam int ROW_W       = 15;
  localparam int MCOL_W      = 4;
  localparam int MIDX_W      = BANK_W + MCOL_W;
  localparam int MEM_WORDS   = 64;
  localparam int PIPE_DEPTH  = 8;
  localparam int BEAT_W      = 5;
  localparam int FIFO_DEPTH  = 8;
  localparam int FIFO_WIDTH  = MIDX_W + DQ_W;
  localparam int SYNC_W      = 1 + 1 + CA_W + DQ_W + 1;

  // Mode register addresses
  localparam logic [7:0] MA_SR_BANK_MASK = 8'h10;
  localparam logic [7:0] MA_CAL_A        = 8'h20;
  localparam logic [7:0] MA_CAL_B        = 8'h28;
  localparam logic [7:0] MA_SOFT_RESET   = 8'h3F;
  localparam logic [3:0] SR_MASK_RESET   = 4'h0;
  localparam logic [3:0] ALL_BANKS       = 4'hF;

  // Command codes on the rising-edge half
  localparam logic [1:0] CMD2_ACT    = 2'h2;
  localparam logic [1:0] CMD2_ACCESS = 2'h1;
  localparam logic [3:0] CMD4_BST    = 4'h3;
  localparam logic [3:0] CMD4_PRE    = 4'hB;
  localparam logic [3:0] CMD4_MRW    = 4'h0;
  localparam logic [3:0] CMD4_MRR    = 4'h8;

  // Field positions
  localparam int RD_SEL_BIT  = 2;
  localparam int AB_BIT      = 4;
  localparam int BANK_LSB    = 7;
  localparam int ROW_R_LSB   = 2;
  localparam int COL_R_LSB   = 5;
  localparam int COL_F_LSB   = 1;
  localparam int MA_R_LSB    = 4;
  localparam int OP_F_LSB    = 2;

  // Burst length codes and beat counts
  localparam logic [1:0] BL_CODE_8  = 2'h1;
  localparam logic [1:0] BL_CODE_16 = 2'h2;
  localparam logic [4:0] BEATS_4    = 5'h04;
  localparam logic [4:0] BEATS_8    = 5'h08;
  localparam logic [4:0] BEATS_16   = 5'h10;

  typedef enum logic [2:0] {
    PK_NONE   = 3'h0,
    PK_READ   = 3'h1,
    PK_WRITE  = 3'h2,
    PK_MRR    = 3'h3,
    PK_BST_RD = 3'h4,
    PK_BST_WR = 3'h5
  } sbc_pipe_kind_e;

  typedef struct packed {
    sbc_pipe_kind_e          kind;
    logic [BANK_W-1:0]       bank;
    logic [MCOL_W-1:0]       col;
    logic [7:0]              data;
  } sbc_pipe_ent_s;

  typedef enum logic [1:0] {
    RD_IDLE  = 2'h0,
    RD_PRE   = 2'h1,
    RD_BURST = 2'h2
  } sbc_rd_state_e;

  typedef enum logic [0:0] {
    WR_IDLE = 1'h0,
    WR_OPEN = 1'h1
  } sbc_wr_state_e;

  function automatic logic [BEAT_W-1:0] burst_beats(input logic [1:0] code);
    case (code)
      BL_CODE_8:  burst_beats = BEATS_8;
      BL_CODE_16: burst_beats = BEATS_16;
      default:    burst_beats = BEATS_4;
    endcase
  endfunction : burst_beats

  // Sequential wrap inside a 16-word window of the bank
  function automatic logic [MIDX_W-1:0] mem_idx(input logic [BANK_W-1:0] bank,
                                               input logic [MCOL_W-1:0] col,
                                               input logic [BEAT_W-1:0] beat);
    mem_idx = {bank, col + beat[MCOL_W-1:0]};
  endfunction : mem_idx

endpackage : sbc_pkg
`default_nettype wire

/* File: sbc_sync.sv */
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clock_i.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/10ps
`default_nettype none
module sbc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sbc_sync_state_s;

  sbc_sync_state_s st_reg;
  sbc_sync_state_s st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
    if (sys_rst_i) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || ce_i) begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;

endmodule : sbc_sync
`default_nettype wire

/* File: sbc_fifo.sv */
// Purpose: Small valid/ready FIFO for captured write beats.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty come from pointers with one extra wrap bit.
`timescale 1ns/10ps
`default_nettype none
module sbc_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } sbc_fifo_state_s;

  sbc_fifo_state_s st_reg;
  sbc_fifo_state_s st_next;
  logic            full;
  logic            empty;

  assign empty       = (st_reg.wr_ptr == st_reg.rd_ptr);
  assign full        = (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]) &&
                       (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = st_reg.mem[st_reg.rd_ptr[AW-1:0]];

  always_comb begin
    st_next = st_reg;
    if (in_valid_i && !full) begin
      st_next.mem[st_reg.wr_ptr[AW-1:0]] = in_data_i;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    if (sys_rst_i) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || ce_i) begin
      st_reg <= st_next;
    end
  end

endmodule : sbc_fifo
`default_nettype wire

/* File: sbc_core_chk.sv */
// Purpose: Port checks of the bank command core.
// Assumes: One clock domain.
// Notes:   Bound from the bench top.
`timescale 1ns/10ps
`default_nettype none
module sbc_core_chk (
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic       self_refresh_i,
  input wire logic       dq_oe_n_o,
  input wire logic       dqs_t_o,
  input wire logic       dqs_oe_n_o,
  input wire logic [3:0] bank_open_o,
  input wire logic [3:0] sr_bank_mask_o,
  input wire logic [3:0] refresh_bank_en_o,
  input wire logic       access_error_o,
  input wire logic       soft_reset_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  mask_dflt_a: assert property ($past(sys_rst_i) |-> sr_bank_mask_o == 4'h0)
    else $error("mask not cleared");
  refresh_lag_a: assert property (refresh_bank_en_o ==
    ($past(self_refresh_i) ? ~$past(sr_bank_mask_o) : 4'hF)) else $error("refresh enable");
  srst_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("reset pulse too long");
  srst_clear_a: assert property (soft_reset_o |-> ##[1:2]
    (sr_bank_mask_o == 4'h0 && bank_open_o == 4'h0 && !access_error_o)) else $error("state kept");
  oe_pair_a: assert property (!dq_oe_n_o |-> !dqs_oe_n_o)
    else $error("data without strobe");
  preamble_a: assert property ($fell(dqs_oe_n_o) |-> dq_oe_n_o && !dqs_t_o)
    else $error("no preamble");
  first_edge_a: assert property ($fell(dq_oe_n_o) |-> $rose(dqs_t_o))
    else $error("first beat off rise");
  burst_end_a: assert property ($rose(dq_oe_n_o) |-> $rose(dqs_oe_n_o))
    else $error("strobe outlives data");
endmodule : sbc_core_chk
`default_nettype wire

/* File: sbc_host_model.sv */
// Purpose: Host side: link clock, command bus, write data and strobe.
// Assumes: Link period of twelve system cycles.
// Notes:   Link clock stops between frames; released buses show inverted data.
`timescale 1ns/10ps
`default_nettype none
module sbc_host_model (
  input  wire logic        clock_i,
  output var  logic        ck_o,
  output var  logic        cs_n_o,
  output var  logic [9:0]  cmd_addr_bus_o,
  output var  logic [15:0] dq_o,
  output var  logic        dqs_o
);
  initial begin
    ck_o = 1'b0;
    cs_n_o = 1'b1;
    cmd_addr_bus_o = 10'h155;
    dq_o = 16'hA5A5;
    dqs_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask : tick
  task automatic clk(input int n);
    repeat (n) begin
      tick(3);
      ck_o = 1'b1;
      tick(6);
      ck_o = 1'b0;
      tick(3);
    end
  endtask : clk
  task automatic cmd(input logic cs_n, input logic [9:0] r, input logic [9:0] f);
    cs_n_o = cs_n;
    cmd_addr_bus_o = r;
    tick(3);
    ck_o = 1'b1;
    tick(3);
    cmd_addr_bus_o = f;
    tick(3);
    ck_o = 1'b0;
    tick(3);
    cs_n_o = 1'b1;
    cmd_addr_bus_o = ~f;
  endtask : cmd
  // Strobe rests low as preamble; data set half a beat before each edge
  task automatic wburst(input logic [63:0] d);
    fork
      clk(4);
      begin
        tick(6);
        for (int i = 0; i < 4; i++) begin
          dq_o = d[16*i +: 16];
          tick(3);
          dqs_o = ~dqs_o;
          tick(3);
        end
        dq_o = ~dq_o;
      end
    join
  endtask : wburst
endmodule : sbc_host_model
`default_nettype wire

/* File: test_sdram_bank_command_core.sv */
// Purpose: Self-checking bench of the bank command core.
// Assumes: Read latency 3, write latency 1; burst of four unless a test sets eight.
// Notes:   Fill of the write buffer is not reached here.
`timescale 1ns/10ps
`default_nettype none
module test_sdram_bank_command_core;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        self_refresh_i = 1'b0;
  wire         ck, cs_n, hdqs;
  wire  [9:0]  ca;
  wire  [15:0] hdq;
  logic [15:0] rdq;
  logic        ce = 1'b1;
  logic [1:0]  bl = 2'h0;
  logic        dq_oe_n, dqs_t, dqs_c, dqs_oe_n, err, srst, ovr, frdy;
  logic [3:0]  bopen, mask, ren;
  int          failures = 0;
  int          n_tests = 0;
  localparam logic [63:0] A = 64'h0A03_0A02_0A01_0A00;
  localparam logic [63:0] B = 64'h0B03_0B02_0B01_0B00;
  always #2 clock_i = ~clock_i;
  sbc_host_model i_host (.clock_i(clock_i), .ck_o(ck), .cs_n_o(cs_n), .cmd_addr_bus_o(ca),
    .dq_o(hdq), .dqs_o(hdqs));
  sbc_core i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .ck_i(ck),
    .cs_n_i(cs_n), .cmd_addr_bus_i(ca), .dq_i(hdq), .dq_o(rdq), .dq_oe_n_o(dq_oe_n),
    .dqs_i(hdqs), .dqs_t_o(dqs_t), .dqs_c_o(dqs_c), .dqs_oe_n_o(dqs_oe_n),
    .read_latency_i(4'h3), .write_latency_i(4'h1), .burst_length_i(bl),
    .self_refresh_i(self_refresh_i), .bank_open_o(bopen), .sr_bank_mask_o(mask),
    .refresh_bank_en_o(ren), .access_error_o(err), .write_overrun_o(ovr),
    .wr_fifo_ready_o(frdy), .soft_reset_o(srst));
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Takes one beat per strobe change while data is driven
  // Counts every beat in the window, so a burst that runs long fails too
  task automatic rd_chk(input logic [9:0] r, input logic [9:0] f, input logic [191:0] e,
                        input int nb = 4);
    logic p;
    int   k;
    p = 1'b0;
    k = 0;
    i_host.cmd(1'b0, r, f);
    fork
      i_host.clk(nb / 2 + 4);
      for (int n = 0; n < 12 * (nb / 2 + 4); n++) begin
        @(negedge clock_i);
        if (dq_oe_n === 1'b0 && dqs_t !== p) begin
          if (k < nb) begin
            chk(rdq, e[16*k +: 16]);
            chk(16'({dqs_oe_n, dqs_c ^ dqs_t}), 16'h0001);
          end
          k++;
        end
        p = dqs_t;
      end
    join
    chk(16'(k), 16'(nb));
    if (k != nb) begin
      wrap_up();
    end
  endtask : rd_chk
  task automatic t_mask;
    chk(16'(mask), 16'h0000);
    chk(16'(ren), 16'h000F);
    i_host.cmd(1'b0, 10'h100, 10'h294);
    i_host.tick(4);
    chk(16'(mask), 16'h0005);
    self_refresh_i = 1'b1;
    i_host.tick(3);
    chk(16'(ren), 16'h000A);
    self_refresh_i = 1'b0;
    i_host.tick(3);
    chk(16'(ren), 16'h000F);
    ce = 1'b0;
    i_host.cmd(1'b0, 10'h100, 10'h000);
    ce = 1'b1;
    i_host.tick(3);
    chk(16'(mask), 16'h0005);
    $display("test mask done");
  endtask : t_mask
  task automatic t_rw;
    rd_chk(10'h208, 10'h000, {4{16'h0055}});
    rd_chk(10'h288, 10'h000, {4{16'h0033}});
    i_host.cmd(1'b0, 10'h082, 10'h000);
    i_host.clk(3);
    chk(16'(bopen), 16'h0002);
    i_host.cmd(1'b0, 10'h081, 10'h000);
    i_host.wburst(A);
    i_host.cmd(1'b0, 10'h081, 10'h002);
    i_host.wburst(B);
    i_host.clk(2);
    chk(16'({ovr, frdy}), 16'h0001);
    rd_chk(10'h085, 10'h002, B);
    rd_chk(10'h085, 10'h000, A);
    rd_chk(10'h0C5, 10'h000, {B[31:0], A[63:32]});
    $display("test write read done");
  endtask : t_rw
  task automatic t_bl8;
    bl = 2'h1;
    i_host.cmd(1'b0, 10'h085, 10'h000);
    i_host.clk(1);
    rd_chk(10'h085, 10'h000, {B, A, A}, 12);
    i_host.cmd(1'b0, 10'h085, 10'h002);
    i_host.clk(1);
    rd_chk(10'h003, 10'h000, B);
    bl = 2'h0;
    $display("test long burst done");
  endtask : t_bl8
  task automatic t_err;
    logic seen;
    seen = 1'b0;
    i_host.cmd(1'b1, 10'h182, 10'h000);
    i_host.clk(2);
    chk(16'(bopen), 16'h0002);
    i_host.cmd(1'b0, 10'h105, 10'h000);
    i_host.clk(6);
    chk(16'(err), 16'h0001);
    i_host.cmd(1'b0, 10'h08B, 10'h000);
    i_host.clk(3);
    chk(16'(bopen), 16'h0000);
    i_host.cmd(1'b0, 10'h182, 10'h000);
    i_host.clk(2);
    chk(16'(bopen), 16'h0008);
    fork
      i_host.cmd(1'b0, 10'h3F0, 10'h000);
      for (int n = 0; n < 40 && !seen; n++) begin
        @(negedge clock_i);
        seen = (srst === 1'b1);
      end
    join
    i_host.tick(3);
    chk(16'(seen), 16'h0001);
    chk(16'({err, bopen, mask}), 16'h0000);
    $display("test error and soft reset done");
  endtask : t_err
  initial begin
    repeat (3) @(negedge clock_i);
    sys_rst_i = 1'b0;
    i_host.tick(3);
    t_mask();
    t_rw();
    t_bl8();
    t_err();
    wrap_up();
  end
endmodule : test_sdram_bank_command_core
bind sbc_core sbc_core_chk i_chk (.clock_i, .sys_rst_i, .self_refresh_i, .dq_oe_n_o,
  .dqs_t_o, .dqs_oe_n_o, .bank_open_o, .sr_bank_mask_o, .refresh_bank_en_o,
  .access_error_o, .soft_reset_o);
`default_nettype wire
